/* File: common/lie_defs.svh */
// Register offsets, field positions and reset values of the interrupt enable clear block
`ifndef LIE_DEFS_SVH
`define LIE_DEFS_SVH

`define LIE_OFS_ENABLE_SET 4'h0
`define LIE_OFS_ENABLE_CLEAR 4'h4
`define LIE_OFS_FLAGS 4'h8
`define LIE_OFS_STATUS 4'hc
`define LIE_BIT_BREAK 0
`define LIE_BIT_WAKE 1
`define LIE_BIT_BUS_IDLE 4
`define LIE_BIT_SINGLE_WAKE 6
`define LIE_BIT_THIRD_WAKE 7
`define LIE_BIT_TRANSMIT 8
`define LIE_BIT_RECEIVE 9
`define LIE_BIT_IDENTIFIER 13
`define LIE_IMPL_MASK 14'h23d3
`define LIE_LIN_MASK 14'h20d0
`define LIE_ENABLE_RESET 14'h0000
`define LIE_NSRC 14

`endif

/* File: common/lie_pkg.sv */
// Types shared by the interrupt enable clear block
package lie_pkg;

    typedef logic [13:0] lie_src_t;

    typedef struct packed {
        logic [3:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } lie_wb_req_t;

endpackage : lie_pkg

/* File: hdl/lie_irq_enable_clear.sv */
// Interrupt enable set/clear register block with Wishbone slave
// Behaviour
// - Writing one to bit 13 disables the identifier interrupt, LIN mode source.
// - Reading the clear register returns each source's current enable state.
// - Written zeros leave enables unchanged; written ones clear implemented enables.
// - Bits 12-10, 5, 3-2 read zero and ignore writes.
// - Writing one to bit 9 disables the receiver interrupt.
// - Writing one to bit 8 disables the transmitter interrupt.
// - Writing one to bit 7 disables the third-wakeup timeout interrupt.
// - Writing one to bit 6 disables the single-wakeup timeout interrupt.
// - Writing one to bit 4 disables the bus-idle timeout interrupt.
// - Writing one to bit 1 disables the wakeup interrupt.
// - Writing one to bit 0 disables the break-detect interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "lie_defs.svh"

module lie_irq_enable_clear (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Interrupt sources
    input wire logic [13:0] event_i,
    input wire logic lin_mode_i,
    // Interrupt outputs
    output logic [13:0] irq_req_o,
    output logic irq_o
);

    lie_pkg::lie_wb_req_t req;
    lie_pkg::lie_src_t wmask;
    lie_pkg::lie_src_t enable;
    lie_pkg::lie_src_t flag;
    lie_pkg::lie_src_t req_raw;
    lie_pkg::lie_src_t mode_mask;
    lie_pkg::lie_src_t wr_bits;
    lie_pkg::lie_src_t set_stb;
    lie_pkg::lie_src_t clr_stb;
    lie_pkg::lie_src_t fclr_stb;
    lie_pkg::lie_src_t req_live;
    lie_pkg::lie_src_t impl_mask;
    logic [31:0] rd_enable;
    logic [31:0] rd_flag;
    logic [31:0] rd_status;
    logic access;
    logic wr;
    logic sel_set;
    logic sel_clr;
    logic sel_flag;
    logic sel_stat;
    logic [31:0] rdata;
    logic ack_q;
    logic [31:0] dat_q;
    lie_pkg::lie_src_t irq_req_q;
    logic irq_q;

    assign req = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
    // One answer per request: ack never stays high two cycles
    assign access = cyc_i & stb_i & ~ack_q;
    assign wr = access & req.we;
    assign sel_set = req.adr == `LIE_OFS_ENABLE_SET;
    assign sel_clr = req.adr == `LIE_OFS_ENABLE_CLEAR;
    assign sel_flag = req.adr == `LIE_OFS_FLAGS;
    assign sel_stat = req.adr == `LIE_OFS_STATUS;
    assign wmask = {{6{req.sel[1]}}, {8{req.sel[0]}}};
    // Reserved positions never reach the storage
    assign wr_bits = req.dat[13:0] & wmask & `LIE_IMPL_MASK;
    assign set_stb = (wr & sel_set) ? wr_bits : 14'h0000;
    assign clr_stb = (wr & sel_clr) ? wr_bits : 14'h0000;
    assign fclr_stb = (wr & sel_flag) ? wr_bits : 14'h0000;
    // LIN-only sources are silent outside LIN mode, break detect outside compatibility
    assign mode_mask = lin_mode_i ? ~14'h0001 : ~`LIE_LIN_MASK;
    assign req_live = req_raw & mode_mask & `LIE_IMPL_MASK;
    // Reserved positions take no event, so their flags stay clear
    assign impl_mask = `LIE_IMPL_MASK;

    genvar g;
    generate
        for (g = 0; g < `LIE_NSRC; g++)
        begin : g_src
            lie_src_cell i_lie_src_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .en_set_i(set_stb[g]),
                .en_clr_i(clr_stb[g]),
                .flag_clr_i(fclr_stb[g]),
                .event_i(event_i[g] & impl_mask[g]),
                .enable_o(enable[g]),
                .flag_o(flag[g]),
                .req_o(req_raw[g])
            );
        end
    endgenerate

    // Both enable views read the same storage; reserved bits read zero
    assign rd_enable = {18'h00000, enable & impl_mask};
    assign rd_flag = {18'h00000, flag & impl_mask};
    assign rd_status = {31'h00000000, lin_mode_i};
    assign rdata = (sel_set | sel_clr) ? rd_enable :
                   sel_flag ? rd_flag :
                   sel_stat ? rd_status :
                   32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
            irq_req_q <= 14'h0000;
            irq_q <= 1'b0;
        end
        else
        begin
            ack_q <= access;
            dat_q <= access ? rdata : dat_q;
            irq_req_q <= req_live;
            irq_q <= |req_live;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign irq_req_o = irq_req_q;
    assign irq_o = irq_q;

    property p_clr_disables;
        @(posedge clk_i) disable iff (rst_i)
        (wr & sel_clr & req.sel[1] & req.dat[13] & ~(wr & sel_set)) |=> !enable[13];
    endproperty
    a_clr_disables: assert property (p_clr_disables) else $error("id enable not cleared");

    property p_read_state;
        @(posedge clk_i) disable iff (rst_i)
        (access & ~req.we & sel_clr) |=> (dat_o[13:0] == $past(enable));
    endproperty
    a_read_state: assert property (p_read_state) else $error("clear read not enable");

    property p_zero_keeps;
        @(posedge clk_i) disable iff (rst_i)
        (wr & sel_clr & req.sel == 4'hf & req.dat == 32'h00000000 & ~set_stb[9]) |=>
            (enable[9] == $past(enable[9]));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed enable");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |-> (dat_o[12:10] == 3'h0 && dat_o[5] == 1'b0 && dat_o[3:2] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

    property p_rx_clear;
        @(posedge clk_i) disable iff (rst_i)
        (clr_stb[9] & ~set_stb[9]) |=> !enable[9] ##1 !irq_req_o[9];
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx enable not cleared");

    property p_tx_clear;
        @(posedge clk_i) disable iff (rst_i)
        (clr_stb[8] & ~set_stb[8]) |=> !enable[8];
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx enable not cleared");

    property p_wake_clear;
        @(posedge clk_i) disable iff (rst_i)
        (clr_stb[7:6] != 2'h0 & set_stb[7:6] == 2'h0) |=> ((enable[7:6] & $past(clr_stb[7:6])) == 2'h0);
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake timeout enable kept");

    property p_low_clear;
        @(posedge clk_i) disable iff (rst_i)
        (clr_stb[4] | clr_stb[1] | clr_stb[0]) & set_stb == 14'h0000 |=>
            ((enable & $past(clr_stb)) == 14'h0000);
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("low enable kept");

    property p_irq_gate;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (irq_req_o == $past(req_live)) && ((irq_req_o & ~$past(enable)) == 14'h0000);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

    // Every taken request is answered at the very next edge
    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i)
        access |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

    // The set view reads the very storage that the clear view clears
    property p_set_read;
        @(posedge clk_i) disable iff (rst_i)
        (access & ~req.we & sel_set) |=> (dat_o == {18'h00000, $past(enable)});
    endproperty
    a_set_read: assert property (p_set_read) else $error("set read not enable");

    // A clear write can only take enables away
    property p_clr_no_set;
        @(posedge clk_i) disable iff (rst_i)
        (wr & sel_clr) |=> ((enable & ~$past(enable)) == 14'h0000);
    endproperty
    a_clr_no_set: assert property (p_clr_no_set) else $error("enable set by clear");

    // Only positions written with a one may change
    property p_zero_keep;
        @(posedge clk_i) disable iff (rst_i)
        (wr & sel_clr) |=> (((enable ^ $past(enable)) & ~$past(req.dat[13:0])) == 14'h0000);
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("zero bit changed enable");

    // Reserved positions hold no enable, no flag and no request
    property p_rsv_store;
        @(posedge clk_i) disable iff (rst_i)
        ((enable | flag | irq_req_o) & ~impl_mask) == 14'h0000;
    endproperty
    a_rsv_store: assert property (p_rsv_store) else $error("reserved bit set");

    // Identifier requests exist in LIN mode only
    property p_id_lin_only;
        @(posedge clk_i) disable iff (rst_i)
        !lin_mode_i |=> !irq_req_o[`LIE_BIT_IDENTIFIER];
    endproperty
    a_id_lin_only: assert property (p_id_lin_only) else $error("id request outside LIN");

    // Wakeup timeouts and bus idle stay quiet in compatibility mode
    property p_lin_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !lin_mode_i |=> ((irq_req_o & `LIE_LIN_MASK) == 14'h0000);
    endproperty
    a_lin_quiet: assert property (p_lin_quiet) else $error("LIN request in compat");

    // Break detect belongs to compatibility mode
    property p_brk_compat;
        @(posedge clk_i) disable iff (rst_i)
        lin_mode_i |=> !irq_req_o[`LIE_BIT_BREAK];
    endproperty
    a_brk_compat: assert property (p_brk_compat) else $error("break request in LIN");

    // The request line drops one edge after the enable does
    property p_tx_drop;
        @(posedge clk_i) disable iff (rst_i)
        (clr_stb[8] & ~set_stb[8]) |-> ##2 !irq_req_o[`LIE_BIT_TRANSMIT];
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("tx request kept");

    // The summary line is the OR of the per-source lines
    property p_irq_level;
        @(posedge clk_i) disable iff (rst_i)
        irq_o == (|irq_req_o);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("summary request wrong");

    // An event sets its flag even when software clears in the same cycle
    property p_flag_sticky;
        @(posedge clk_i) disable iff (rst_i)
        ((event_i & impl_mask) != 14'h0000) |=>
            ((flag & $past(event_i & impl_mask)) == $past(event_i & impl_mask));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("event flag lost");

    property p_flag_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr & sel_flag & req.sel == 4'hf & event_i == 14'h0000) |=>
            ((flag & $past(req.dat[13:0])) == 14'h0000);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_flag_read;
        @(posedge clk_i) disable iff (rst_i)
        (access & ~req.we & sel_flag) |=> (dat_o == {18'h00000, $past(flag)});
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

    property p_mode_read;
        @(posedge clk_i) disable iff (rst_i)
        (access & ~req.we & sel_stat) |=> (dat_o == {31'h00000000, $past(lin_mode_i)});
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

    // Reset is synchronous: storage and outputs are at rest one edge later
    property p_reset_quiet;
        @(posedge clk_i)
        rst_i |=> (!ack_o && !irq_o && irq_req_o == 14'h0000 && enable == `LIE_ENABLE_RESET);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");

    c_clear_write: cover property (@(posedge clk_i) disable iff (rst_i) clr_stb != 14'h0000);
    c_irq_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    c_set_then_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        set_stb[9] ##[1:20] clr_stb[9]);
    c_id_request: cover property (@(posedge clk_i) disable iff (rst_i)
        lin_mode_i & irq_req_o[`LIE_BIT_IDENTIFIER]);
    c_break_request: cover property (@(posedge clk_i) disable iff (rst_i)
        !lin_mode_i & irq_req_o[`LIE_BIT_BREAK]);

endmodule : lie_irq_enable_clear

`default_nettype wire

/* File: hdl/lie_src_cell.sv */
// One interrupt source: enable storage, sticky flag and gated request
`timescale 1ns/100ps
`default_nettype none

module lie_src_cell (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Software strobes
    input wire logic en_set_i,
    input wire logic en_clr_i,
    input wire logic flag_clr_i,
    // Hardware event
    input wire logic event_i,
    // State
    output logic enable_o,
    output logic flag_o,
    output logic req_o
);

    logic enable_q;
    logic enable_d;
    logic flag_q;
    logic flag_d;

    // Set wins over clear when both are written together
    assign enable_d = en_set_i | (enable_q & ~en_clr_i);
    // A new event in the clear cycle is kept
    assign flag_d = event_i | (flag_q & ~flag_clr_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            enable_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            enable_q <= enable_d;
            flag_q <= flag_d;
        end
    end

    assign enable_o = enable_q;
    assign flag_o = flag_q;
    assign req_o = flag_q & enable_q;

endmodule : lie_src_cell

`default_nettype wire

/* File: tb/lie_irq_enable_clear_test.sv */
// Self-checking bench for the interrupt enable clear block
`timescale 1ns/100ps
`default_nettype none
`include "lie_defs.svh"
`define CHK(got, exp) \
    begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module lie_irq_enable_clear_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [13:0] event_r = 14'h0;
    logic lin_mode = 1'b0;
    logic [13:0] irq_req_o;
    logic irq_o;
    logic [31:0] seed = 32'h64a74f85;
    logic [31:0] q;
    logic [13:0] en = 14'h0;
    logic [13:0] flg = 14'h0;
    logic [3:0] lanes = 4'hf;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;

    always #10 clk_i = ~clk_i;

    lie_irq_enable_clear i_lie_irq_enable_clear (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .event_i(event_r), .lin_mode_i(lin_mode), .irq_req_o(irq_req_o), .irq_o(irq_o)
    );

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Requests gated by mode: break source only outside LIN mode
    function logic [13:0] exp_req(input logic [13:0] f, input logic [13:0] e, input logic m);
        logic [13:0] g;
        g = m ? (`LIE_IMPL_MASK & ~14'h0001) : (`LIE_IMPL_MASK & ~`LIE_LIN_MASK);
        return f & e & g;
    endfunction : exp_req

    // Classic single cycle; entered just after a rising edge
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= lanes;
        @(posedge clk_i);
        // Only the bench timeout ends a wait for the answer
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // A hung handshake would stall the run forever
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    initial
    begin
        logic [31:0] d;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `LIE_OFS_ENABLE_CLEAR, 32'h0);
        `CHK(q, 32'h0)
        // Walk a single one across every position, reserved ones included
        for (int i = 0; i < 14; i++)
        begin
            wb(1'b1, `LIE_OFS_ENABLE_SET, 32'hffffffff);
            wb(1'b1, `LIE_OFS_ENABLE_CLEAR, 32'h1 << i);
            wb(1'b0, `LIE_OFS_ENABLE_CLEAR, 32'h0);
            `CHK(q, {18'h0, `LIE_IMPL_MASK & ~(14'h1 << i)})
        end
        // The walk leaves only its last position cleared
        en = `LIE_IMPL_MASK & ~(14'h1 << `LIE_BIT_IDENTIFIER);
        for (int k = 0; k < 40; k++)
        begin
            d = rnd();
            wb(1'b1, `LIE_OFS_ENABLE_SET, d);
            en = en | (d[13:0] & `LIE_IMPL_MASK);
            d = rnd();
            if (k % 5 == 0)
                d = 32'h0;
            // Some clears use one byte lane only, or none
            if (k % 3 == 1)
                lanes = d[17:14];
            wb(1'b1, `LIE_OFS_ENABLE_CLEAR, d);
            en = en & ~(d[13:0] & `LIE_IMPL_MASK & {{6{lanes[1]}}, {8{lanes[0]}}});
            lanes = 4'hf;
            wb(1'b0, `LIE_OFS_ENABLE_CLEAR, 32'h0);
            `CHK(q, {18'h0, en})
            wb(1'b0, `LIE_OFS_ENABLE_SET, 32'h0);
            `CHK(q, {18'h0, en})
            d = rnd();
            lin_mode <= d[31];
            event_r <= d[13:0];
            flg = flg | (d[13:0] & `LIE_IMPL_MASK);
            @(posedge clk_i);
            event_r <= 14'h0;
            repeat (3) @(posedge clk_i);
            `CHK(irq_req_o, exp_req(flg, en, d[31]))
            `CHK(irq_o, |exp_req(flg, en, d[31]))
            wb(1'b0, `LIE_OFS_FLAGS, 32'h0);
            `CHK(q, {18'h0, flg})
            wb(1'b0, `LIE_OFS_STATUS, 32'h0);
            `CHK(q, {31'h0, d[31]})
            if (k % 4 == 3)
            begin
                wb(1'b1, `LIE_OFS_FLAGS, 32'hffffffff);
                flg = 14'h0;
            end
        end
        // A second reset in mid-run returns storage and outputs to rest
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(irq_req_o, 14'h0)
        `CHK(irq_o, 1'b0)
        wb(1'b0, `LIE_OFS_ENABLE_CLEAR, 32'h0);
        `CHK(q, {18'h0, `LIE_ENABLE_RESET})
        finish_test();
    end
endmodule : lie_irq_enable_clear_test
`default_nettype wire
